/* src/dtcu_trace_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - nine register bytes: two comparators, fifo word, three control bytes
// - registers sit in the high register area of the memory map
// - comparator bytes reset to zero, always readable, locked while armed
// - fifo high byte reads upper half of current word; writes ignored
// - event-only modes store low byte only; high byte reads zero
// - reading fifo high byte never advances the fifo
// - reading fifo low byte returns lower half then advances
// - no fifo advance on low-byte reads while armed
// - unarmed low-byte read stores last fetched opcode address at tail
// - ninth read returns the address captured by the first read
// - control register readable and writable at any time
// - bit 7 enables unit; setting blocked while secured
// - bit 6 arms; run end or writing zero clears it
// - bit 5 picks force or tag break type
// - bit 4 gates break requests; fifo storage continues regardless
// - end trace breaks on trigger, begin trace on fifo full
// - qualification select picks the hit_a and hit_b source, so it alters break timing in modes that use them
// - bits 2,3 qualify comparator a by bus direction
// - bits 0,1 qualify comparator b by bus direction
// - run ends on full (begin) or trigger (end); arm clears
// - arm flag mirrors arm bit while enabled
module dtcu_trace_unit
	import dtcu_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [15:0] reg_addr,
	input  wire logic        reg_rd,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	output var  logic [7:0]  reg_rdata,
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_read,
	input  wire logic        cpu_valid,
	input  wire logic        cpu_opfetch,
	input  wire logic        cpu_exec,
	input  wire logic        secure,
	output var  logic        break_req,
	output var  logic        break_tag
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0]  cmp_a_hi, cmp_a_lo, cmp_b_hi, cmp_b_lo;
	logic [7:0]  control;
	logic [7:0]  trigger;
	logic        flag_a, flag_b;
	logic [3:0]  count;
	logic [15:0] fifo_mem [DEPTH];
	logic [AW-1:0] head;
	logic [AW-1:0] wptr;
	logic [15:0] last_fetch;
	logic        a_seen;
	logic        began;
	logic [15:0] tag_a_addr, tag_b_addr;

	dtcu_match_if ma ();
	dtcu_match_if mb ();

	dtcu_comparator u_cmp_a (
		.bus_addr (cpu_addr),
		.bus_read (cpu_read),
		.m        (ma)
	);
	dtcu_comparator u_cmp_b (
		.bus_addr (cpu_addr),
		.bus_read (cpu_read),
		.m        (mb)
	);

	assign ma.value    = {cmp_a_hi, cmp_a_lo};
	assign ma.dir_en   = control[BIT_A_DIR_EN];
	assign ma.dir_read = control[BIT_A_DIR];
	assign mb.value    = {cmp_b_hi, cmp_b_lo};
	assign mb.dir_en   = control[BIT_B_DIR_EN];
	assign mb.dir_read = control[BIT_B_DIR];

	function automatic logic sel(input logic [15:0] a, input logic [3:0] o);
		sel = (a == BASE_ADDR + {12'h000, o});
	endfunction

	// decode, all within the high register area
	wire in_win   = (reg_addr >= BASE_ADDR) &&
		(reg_addr <= BASE_ADDR + {12'h000, OFF_STATUS});
	wire [3:0] idx = 4'(reg_addr - BASE_ADDR);
	wire enabled  = control[BIT_ENABLE];
	wire armed    = control[BIT_ARM] && enabled;
	wire wr_ctl   = reg_wr && sel(reg_addr, OFF_CONTROL);
	wire wr_cmp   = reg_wr && in_win && !control[BIT_ARM];
	wire wr_trg   = reg_wr && sel(reg_addr, OFF_TRIGGER) && !control[BIT_ARM];
	wire rd_flo   = reg_rd && sel(reg_addr, OFF_FIFO_LOW);
	wire [3:0] mode = trigger[3:0];
	wire event_only = (mode == 4'(DTCU_EVENT_B)) ||
		(mode == 4'(DTCU_A_THEN_EVENT_B));
	wire begin_trace = trigger[BIT_BEGIN] || event_only;
	wire qual_sel = trigger[BIT_QUAL_SEL];

	// hit_a and hit_b look at the bus with qual_sel clear, at executed opcodes with qual_sel set; bus_b and range triggers always look at the bus
	wire bus_a  = cpu_valid && ma.hit;
	wire bus_b  = cpu_valid && mb.hit;
	wire ex_a   = cpu_exec && (last_fetch == tag_a_addr);
	wire ex_b   = cpu_exec && (last_fetch == tag_b_addr);
	wire hit_a  = qual_sel ? ex_a : bus_a;
	wire hit_b  = qual_sel ? ex_b : bus_b;
	wire in_rng = cpu_valid && !ma.below && !mb.above;
	wire out_rng= cpu_valid && (ma.below || mb.above);

	logic trig;
	always_comb
	begin
		case (mode)
			4'(DTCU_A_ONLY):         trig = hit_a;
			4'(DTCU_A_OR_B):         trig = hit_a || hit_b;
			4'(DTCU_A_THEN_B):       trig = a_seen && hit_b;
			4'(DTCU_EVENT_B):        trig = hit_b;
			4'(DTCU_A_THEN_EVENT_B): trig = a_seen && hit_b;
			4'(DTCU_A_AND_B):        trig = hit_a && bus_b;
			4'(DTCU_A_NOT_B):        trig = hit_a && !bus_b;
			4'(DTCU_INSIDE):         trig = in_rng;
			4'(DTCU_OUTSIDE):        trig = out_rng;
			default:                 trig = 1'b0;
		endcase
	end

	// what gets stored: event data in low byte, else fetched opcode address
	wire [15:0] store_word = event_only ? {8'h00, cpu_addr[7:0]} : last_fetch;
	wire store_evt = event_only ? (trig && (mode != 4'(DTCU_A_THEN_EVENT_B) ||
		a_seen)) : (cpu_opfetch && (!begin_trace || began));
	wire fifo_full = (count == 4'(DEPTH));
	wire do_store  = armed && store_evt && !(begin_trace && fifo_full);
	wire full_next = begin_trace && do_store && (count == 4'(DEPTH - 1));
	wire run_end   = armed && (begin_trace ? full_next : trig);
	// break timing comes from trace type and the trigger, whose source qual_sel selects
	wire brk_now   = run_end && control[BIT_BRK_EN];

	wire arm_write = wr_ctl && reg_wdata[BIT_ARM];
	wire [7:0] next_control = {
		reg_wdata[BIT_ENABLE] && (!secure || control[BIT_ENABLE]),
		reg_wdata[BIT_ARM] && reg_wdata[BIT_ENABLE],
		reg_wdata[5:0]};

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			control <= RST_BYTE;
		else if (wr_ctl)
			control <= next_control;
		else if (run_end || !enabled)
			control[BIT_ARM] <= 1'b0;
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cmp_a_hi <= RST_BYTE;
			cmp_a_lo <= RST_BYTE;
			cmp_b_hi <= RST_BYTE;
			cmp_b_lo <= RST_BYTE;
			trigger  <= RST_BYTE;
		end
		else
		begin
			if (wr_cmp && idx == OFF_CMP_A_HIGH) cmp_a_hi <= reg_wdata;
			if (wr_cmp && idx == OFF_CMP_A_LOW)  cmp_a_lo <= reg_wdata;
			if (wr_cmp && idx == OFF_CMP_B_HIGH) cmp_b_hi <= reg_wdata;
			if (wr_cmp && idx == OFF_CMP_B_LOW)  cmp_b_lo <= reg_wdata;
			if (wr_trg) trigger <= {reg_wdata[7:6], 2'b00, reg_wdata[3:0]};
		end
	end

	// run bookkeeping; a new arm restarts flags and count
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag_a <= 1'b0;
			flag_b <= 1'b0;
			a_seen <= 1'b0;
			began  <= 1'b0;
			count  <= RST_COUNT;
		end
		else if (arm_write)
		begin
			flag_a <= 1'b0;
			flag_b <= 1'b0;
			a_seen <= 1'b0;
			began  <= 1'b0;
			count  <= RST_COUNT;
		end
		else if (armed)
		begin
			flag_a <= flag_a || hit_a;
			flag_b <= flag_b || hit_b;
			a_seen <= a_seen || hit_a;
			began  <= began || trig;
			if (do_store && !fifo_full)
				count <= count + 4'h1;
		end
	end

	// tag tracking: remember which fetched opcode matched
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			last_fetch <= 16'h0000;
			tag_a_addr <= 16'hffff;
			tag_b_addr <= 16'hffff;
		end
		else if (cpu_opfetch)
		begin
			last_fetch <= cpu_addr;
			tag_a_addr <= bus_a ? cpu_addr : tag_a_addr;
			tag_b_addr <= bus_b ? cpu_addr : tag_b_addr;
		end
	end

	// circular store: oldest word at head; fill in place while armed
	wire unarmed_read = rd_flo && !armed;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			head <= '0;
			wptr <= '0;
		end
		else if (arm_write)
		begin
			head <= '0;
			wptr <= '0;
		end
		else if (do_store)
		begin
			wptr <= AW'(wptr + 1'b1);
			if (fifo_full)
				head <= AW'(head + 1'b1);
		end
		else if (unarmed_read)
			head <= AW'(head + 1'b1);
	end

	// an unarmed read pushes the last fetch behind the word just read,
	// so eight reads later that sample comes back out
	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_fifo
			always_ff @(posedge mclk)
			begin
				if (do_store && wptr == AW'(gi))
					fifo_mem[gi] <= store_word;
				else if (unarmed_read && head == AW'(gi))
					fifo_mem[gi] <= last_fetch;
			end
		end
	endgenerate

	wire [15:0] cur_word = fifo_mem[head];
	logic [7:0] rd_mux;
	always_comb
	begin
		case (idx)
			OFF_CMP_A_HIGH: rd_mux = cmp_a_hi;
			OFF_CMP_A_LOW:  rd_mux = cmp_a_lo;
			OFF_CMP_B_HIGH: rd_mux = cmp_b_hi;
			OFF_CMP_B_LOW:  rd_mux = cmp_b_lo;
			OFF_FIFO_HIGH:  rd_mux = event_only ? 8'h00 : cur_word[15:8];
			OFF_FIFO_LOW:   rd_mux = cur_word[7:0];
			OFF_CONTROL:    rd_mux = control;
			OFF_TRIGGER:    rd_mux = trigger;
			OFF_STATUS:     rd_mux = {flag_a, flag_b, armed, 1'b0, count};
			default:        rd_mux = 8'h00;
		endcase
	end

	// registered read data: one cycle after the read strobe
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= RST_BYTE;
			break_req <= 1'b0;
			break_tag <= 1'b0;
		end
		else
		begin
			reg_rdata <= (reg_rd && in_win) ? rd_mux : 8'h00;
			break_req <= brk_now;
			break_tag <= brk_now && control[BIT_TAG];
		end
	end
endmodule // dtcu_trace_unit
`default_nettype wire

/* src/dtcu_pkg.sv */
package dtcu_pkg;
	// register indices inside the unit's nine-byte window
	localparam logic [3:0] OFF_CMP_A_HIGH   = 4'h0;
	localparam logic [3:0] OFF_CMP_A_LOW    = 4'h1;
	localparam logic [3:0] OFF_CMP_B_HIGH   = 4'h2;
	localparam logic [3:0] OFF_CMP_B_LOW    = 4'h3;
	localparam logic [3:0] OFF_FIFO_HIGH    = 4'h4;
	localparam logic [3:0] OFF_FIFO_LOW     = 4'h5;
	localparam logic [3:0] OFF_CONTROL      = 4'h6;
	localparam logic [3:0] OFF_TRIGGER      = 4'h7;
	localparam logic [3:0] OFF_STATUS       = 4'h8;
	// high register area base, full 16-bit address of the window
	localparam logic [15:0] BASE_ADDR       = 16'h1810;
	// control bit positions
	localparam int BIT_ENABLE               = 7;
	localparam int BIT_ARM                  = 6;
	localparam int BIT_TAG                  = 5;
	localparam int BIT_BRK_EN               = 4;
	localparam int BIT_A_DIR                = 3;
	localparam int BIT_A_DIR_EN             = 2;
	localparam int BIT_B_DIR                = 1;
	localparam int BIT_B_DIR_EN             = 0;
	// trigger register bit positions
	localparam int BIT_QUAL_SEL             = 7;
	localparam int BIT_BEGIN                = 6;
	localparam logic [7:0] RST_BYTE         = 8'h00;
	localparam logic [3:0] RST_COUNT        = 4'h0;
	localparam int FIFO_DEPTH               = 8;
	typedef enum logic [3:0] {
		DTCU_A_ONLY, DTCU_A_OR_B, DTCU_A_THEN_B, DTCU_EVENT_B,
		DTCU_A_THEN_EVENT_B, DTCU_A_AND_B, DTCU_A_NOT_B, DTCU_INSIDE,
		DTCU_OUTSIDE
	} dtcu_mode_e;
endpackage

/* src/dtcu_match_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dtcu_match_if;
	logic [15:0] value;
	logic        dir_en;
	logic        dir_read;
	logic        hit;
	logic        below;
	logic        above;
	modport ctrl (output value, output dir_en, output dir_read,
		input hit, input below, input above);
	modport cmp (input value, input dir_en, input dir_read,
		output hit, output below, output above);
endinterface // dtcu_match_if
`default_nettype wire

/* src/dtcu_comparator.sv */
`timescale 1ns/1ps
`default_nettype none
module dtcu_comparator
	import dtcu_pkg::*;
(
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_read,
	dtcu_match_if.cmp        m
);
	wire dir_ok;
	// direction only filters when enabled
	assign dir_ok  = !m.dir_en || (m.dir_read == bus_read);
	assign m.hit   = (bus_addr == m.value) && dir_ok;
	assign m.below = bus_addr < m.value;
	assign m.above = bus_addr > m.value;
endmodule // dtcu_comparator
`default_nettype wire

/* verif/dtcu_cpu_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dtcu_cpu_model (
	input  wire logic        mclk,
	input  wire logic        go,
	input  wire logic [15:0] addr,
	input  wire logic        rd,
	input  wire logic        fetch,
	output var  logic [15:0] cpu_addr,
	output var  logic        cpu_read,
	output var  logic        cpu_valid,
	output var  logic        cpu_opfetch,
	output var  logic        cpu_exec
);
	initial {cpu_addr, cpu_read, cpu_valid, cpu_opfetch, cpu_exec} = '0;
	// idle bus inverts its lines every cycle, so a stale address comes back on every second idle cycle
	always @(posedge mclk)
	begin
		cpu_valid <= go;
		cpu_opfetch <= go & fetch;
		cpu_exec <= cpu_opfetch;
		cpu_addr <= go ? addr : ~cpu_addr;
		cpu_read <= go ? rd : ~cpu_read;
	end
endmodule // dtcu_cpu_model
`default_nettype wire

/* verif/dtcu_trace_unit_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module dtcu_trace_unit_sva
	import dtcu_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
)(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [15:0] reg_addr,
	input wire logic        reg_rd,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        secure,
	input wire logic        break_req,
	input wire logic        break_tag
);
	wire logic at_ctl = reg_addr == BASE_ADDR + OFF_CONTROL;
	wire logic at_ah = reg_addr == BASE_ADDR + OFF_CMP_A_HIGH;
	wire logic ctl_wr = reg_wr && at_ctl;
	wire logic ctl_rd = reg_rd && at_ctl;
	wire logic tr_rd = reg_rd && reg_addr == BASE_ADDR + OFF_TRIGGER;
	wire logic miss = reg_rd && (reg_addr < BASE_ADDR
		|| reg_addr > BASE_ADDR + 16'h0008);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero after idle cycle");
	unmapped_zero_a: assert property (miss |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	trig_fixed_a: assert property (tr_rd |=> reg_rdata[5:4] == 2'b00)
		else $error("trigger bits 5:4 not zero");
	tag_needs_req_a: assert property (break_tag |-> break_req)
		else $error("break tag without request");
	break_pulse_a: assert property (break_req |=> !break_req)
		else $error("break request longer than one cycle");
	brk_gated_a: assert property (ctl_wr && !reg_wdata[4] |-> ##2 !break_req)
		else $error("break with break enable off");
	ctl_clear_a: assert property (ctl_wr && reg_wdata == 8'h00 ##1 !reg_wr
		##1 ctl_rd |=> reg_rdata == 8'h00) else $error("control not cleared");
	secure_lock_a: assert property (ctl_wr && reg_wdata == 8'h00 ##1 !reg_wr
		##1 ctl_wr && secure && reg_wdata[7] ##1 !reg_wr ##1 ctl_rd
		|=> !reg_rdata[7]) else $error("enable set while secured");
	cmp_write_a: assert property (ctl_wr && !reg_wdata[6] ##1 !reg_wr
		##1 reg_wr && at_ah ##1 !reg_wr ##1 reg_rd && at_ah
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("compare write lost");
	cover property (break_req && break_tag);
	cover property (break_req && !break_tag);
	cover property (ctl_rd);
endmodule // dtcu_trace_unit_sva
bind dtcu_trace_unit dtcu_trace_unit_sva #(.DEPTH(DEPTH)) chk (.mclk(mclk),
	.rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
	.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .secure(secure),
	.break_req(break_req), .break_tag(break_tag));
`default_nettype wire

/* verif/dtcu_trace_unit_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dtcu_trace_unit_test;
	import dtcu_pkg::*;
	logic        mclk = 0, rst_n = 0, reg_rd = 0, reg_wr = 0, secure = 0;
	logic        q_go = 0, q_rd = 0, q_fetch = 0;
	logic [15:0] reg_addr = '0, q_addr = '0;
	logic [7:0]  reg_wdata = '0, reg_rdata, got;
	wire logic [15:0] cpu_addr;
	wire logic   cpu_read, cpu_valid, cpu_opfetch, cpu_exec;
	wire logic   break_req, break_tag;
	int          err_count = 0, compares = 0, cycles = 0, hits, tags;
	localparam logic [7:0] TC [9] = '{8'hdc, 8'hdc, 8'hd4, 8'hd4, 8'hd3,
		8'hd3, 8'hd0, 8'hf0, 8'hc0};
	localparam logic [8:0] TR = 9'b000100110;
	localparam logic [8:0] TB = 9'b011101010;
	initial forever #4 mclk = ~mclk;
	dtcu_trace_unit dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .cpu_addr(cpu_addr), .cpu_read(cpu_read),
		.cpu_valid(cpu_valid), .cpu_opfetch(cpu_opfetch),
		.cpu_exec(cpu_exec), .secure(secure), .break_req(break_req),
		.break_tag(break_tag));
	dtcu_cpu_model cpu (.mclk(mclk), .go(q_go), .addr(q_addr), .rd(q_rd),
		.fetch(q_fetch), .cpu_addr(cpu_addr), .cpu_read(cpu_read),
		.cpu_valid(cpu_valid), .cpu_opfetch(cpu_opfetch),
		.cpu_exec(cpu_exec));
	task automatic conclude;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			err_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_n(input int g, input int e);
		chk_b(8'(g), 8'(e));
	endtask
	task automatic wr(input logic [3:0] o, input logic [7:0] d);
		@(negedge mclk);
		reg_wr = 1;
		reg_addr = BASE_ADDR + o;
		reg_wdata = d;
		@(negedge mclk);
		reg_wr = 0;
	endtask
	task automatic rd(input logic [3:0] o);
		@(negedge mclk);
		reg_rd = 1;
		reg_addr = BASE_ADDR + o;
		@(negedge mclk);
		reg_rd = 0;
		got = reg_rdata;
	endtask
	// one bus cycle, then count break pulses over a short bounded window
	task automatic cyc(input logic [15:0] a, input logic r, input logic f,
		input int eb, input int et);
		@(negedge mclk);
		q_go = 1;
		q_addr = a;
		q_rd = r;
		q_fetch = f;
		@(negedge mclk);
		q_go = 0;
		hits = 0;
		tags = 0;
		repeat (4)
		begin
			@(negedge mclk);
			hits += (break_req === 1'b1);
			tags += (break_tag === 1'b1);
		end
		chk_n(hits, eb);
		chk_n(tags, et);
	endtask
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			err_count++;
			conclude();
		end
	end
	initial
	begin
		repeat (16) @(negedge mclk);
		rst_n = 1;
		for (int i = 0; i < 10; i++)
			if (i != 4 && i != 5)
			begin
				rd(4'(i));
				chk_b(got, 8'h00);
			end
		wr(OFF_CONTROL, 8'h9f);
		wr(OFF_CMP_A_HIGH, 8'h12);
		rd(OFF_CMP_A_HIGH);
		chk_b(got, 8'h12);
		wr(OFF_CMP_A_LOW, 8'h34);
		wr(OFF_CMP_B_HIGH, 8'h22);
		wr(OFF_CMP_B_LOW, 8'h22);
		rd(OFF_CONTROL);
		chk_b(got, 8'h9f);
		wr(OFF_TRIGGER, 8'h00);
		cyc(16'h1234, 1, 0, 0, 0);
		wr(OFF_CONTROL, 8'hd0);
		rd(OFF_STATUS);
		chk_b(got & 8'h20, 8'h20);
		wr(OFF_CMP_A_HIGH, 8'h55);
		rd(OFF_CMP_A_HIGH);
		chk_b(got, 8'h12);
		cyc(16'h1235, 0, 0, 0, 0);
		cyc(16'h1234, 0, 0, 1, 0);
		rd(OFF_CONTROL);
		chk_b(got, 8'h90);
		rd(OFF_STATUS);
		chk_b(got & 8'h20, 8'h00);
		for (int i = 0; i < 9; i++)
		begin
			wr(OFF_CONTROL, 8'h00);
			wr(OFF_TRIGGER, (i inside {[4:6]}) ? 8'h01 : 8'h00);
			wr(OFF_CONTROL, TC[i]);
			cyc((i inside {[4:6]}) ? 16'h2222 : 16'h1234, TR[i], 0, TB[i],
				TB[i] & TC[i][5]);
		end
		secure = 1;
		wr(OFF_CONTROL, 8'h00);
		rd(OFF_CONTROL);
		chk_b(got, 8'h00);
		wr(OFF_CONTROL, 8'h00);
		wr(OFF_CONTROL, 8'h80);
		rd(OFF_CONTROL);
		chk_b(got, 8'h00);
		secure = 0;
		wr(OFF_CONTROL, 8'h80);
		for (int i = 0; i < 16; i++)
		begin
			cyc({8'h50 + 8'(i), 8'ha0 + 8'(i)}, 0, 1, 0, 0);
			if (i == 9)
			begin
				wr(OFF_FIFO_LOW, 8'hff);
				wr(OFF_FIFO_HIGH, 8'hff);
			end
			if (i >= 8)
			begin
				rd(OFF_FIFO_HIGH);
				rd(OFF_FIFO_HIGH);
				chk_b(got, 8'h48 + 8'(i));
				rd(OFF_FIFO_LOW);
				chk_b(got, 8'h98 + 8'(i));
			end
			else
				rd(OFF_FIFO_LOW);
		end
		// event-only capture armed: high byte reads zero, low reads hold
		wr(OFF_TRIGGER, 8'h03);
		wr(OFF_CONTROL, 8'hc0);
		rd(OFF_FIFO_HIGH);
		chk_b(got, 8'h00);
		rd(OFF_FIFO_LOW);
		chk_b(got, 8'ha8);
		rd(OFF_FIFO_LOW);
		chk_b(got, 8'ha8);
		wr(OFF_CONTROL, 8'h00);
		conclude();
	end
endmodule // dtcu_trace_unit_test
`default_nettype wire
